/* File: cmq_consts.svh */
// register offsets, field positions, reset values and timing figures of the comparator event qualifier
// assumes inclusion by bare name from the files of this block
`ifndef CMQ_CONSTS_SVH
`define CMQ_CONSTS_SVH

`define CMQ_ADDR_IRQ_CTRL   8'hbf
`define CMQ_ADDR_CMP1_CTRL  8'hc1
`define CMQ_ADDR_CMP2_CTRL  8'hc2
`define CMQ_ADDR_CMP3_CTRL  8'hc3
`define CMQ_ADDR_CMP4_CTRL  8'hc4
`define CMQ_ADDR_CMP5_CTRL  8'hc5
`define CMQ_ADDR_QUAL_23    8'hc6
`define CMQ_ADDR_QUAL_45    8'hc7
`define CMQ_ADDR_EDGE_SEL   8'hd7

`define CMQ_BIT_ENABLE      7
`define CMQ_BIT_HYST        6
`define CMQ_BIT_WINDOW_SEL  7
`define CMQ_REF_MSB         5
`define CMQ_DBT_MSB         4

`define CMQ_MASK_CMP1_CTRL  8'hdf
`define CMQ_MASK_QUAL_23    8'hf7
`define CMQ_MASK_QUAL_45    8'h77
`define CMQ_MASK_EDGE_SEL   8'h1f

`define CMQ_RST_CTRL        8'h00
`define CMQ_RST_QUAL_23     8'h77
`define CMQ_RST_QUAL_45     8'h77

// pulse-generator tick: every 2 or every 4 system clocks
`define CMQ_TICK_DIV2_LAST  2'h1
`define CMQ_TICK_DIV4_LAST  2'h3

`endif

/* File: cmq_pkg.sv */
// types of the comparator event qualifier
// assumes cmq_consts.svh is compiled alongside
package cmq_pkg;

  // control levels sent to the five analogue comparators
  typedef struct packed {
    logic [4:0]      enable;
    logic [4:0]      hysteresis_enable;
    logic [3:0][5:0] reference_code;
  } cmq_analog_ctrl_t;

  typedef struct packed {
    logic [4:0] meta;
    logic [4:0] stable;
  } cmq_sync_t;

  typedef struct packed {
    logic [7:0]      irq_ctrl;
    logic [4:0][7:0] cmp_ctrl;
    logic [7:0]      qual_23;
    logic [7:0]      qual_45;
    logic [7:0]      edge_sel;
    logic [7:0]      rdata;
    logic [1:0]      prescale_cnt;
    logic [4:0]      cmp_prev;
    logic [7:0]      fall_cnt;
    logic [2:0][7:0] low_cnt;
    logic [2:0]      low_done;
    logic [4:0]      dbnc_cnt;
    logic            dbnc_out;
    logic            irq;
  } cmq_state_t;

endpackage

/* File: cmq_sync.sv */
// two-stage synchroniser for the five comparator outputs
// assumes the comparator outputs are asynchronous to clk_sys
`timescale 1ns/1ns
module cmq_sync (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // comparator levels
  input  wire logic [4:0] async_in,
  output      logic [4:0] sync_out
);

  cmq_pkg::cmq_sync_t st_r;
  cmq_pkg::cmq_sync_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // comparator outputs rest high, so starting high avoids a false low or edge after reset
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule

/* File: cmq_top.sv */
// comparator event qualifier: control registers, qualification counters, debounce and interrupt request
// assumes a byte-wide special-function-register port and synchronous register strobes
// Functional notes
// - comparator two needs 2^code consecutive falling edges
// - comparator three low for 2^code ticks
// - comparators four, five low for 2^code ticks
// - window select limits comparator three to pulse-active
// - hardware sets flags, software writes zero clears
// - per-flag interrupt enables in bits 7..4
// - edge select bits 1..4 choose rise/fall
// - enable bit 7 per comparator, resets zero
// - hysteresis bit 6 per comparator, resets zero
// - comparator one debounced count times tick period in synchronous mode, else follows the input
// - zero debounce count bypasses comparator one
// - six-bit reference code per comparator two..five
// - group enable gates every comparator interrupt
// - tick is clock over two or four
// - comparator one edge select in bit 0
`timescale 1ns/1ns
`include "cmq_consts.svh"
module cmq_top (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // register port
  input  wire logic [7:0]                sfr_addr,
  input  wire logic                      sfr_wr_en,
  input  wire logic                      sfr_rd_en,
  input  wire logic [7:0]                sfr_wdata,
  output      logic [7:0]                sfr_rdata,
  // settings held outside this block
  input  wire logic                      comparator_group_irq_enable,
  input  wire logic                      pulse_gen_prescale_select,
  input  wire logic                      pulse_gen_sync_mode,
  input  wire logic                      pulse_gen_output_active,
  // analogue side
  input  wire logic [4:0]                comparator_raw,
  output      cmq_pkg::cmq_analog_ctrl_t analog_ctrl,
  // results
  output      logic                      comparator_one_debounced,
  output      logic [3:0]                qualified_flags,
  output      logic                      comparator_irq
);

  cmq_pkg::cmq_state_t st_r;
  cmq_pkg::cmq_state_t st_nxt;
  logic [4:0]          cmp_s;
  logic                tick;
  logic [3:0]          qual_set;
  logic [4:0]          edge_evt;

  function automatic logic [7:0] qual_target(input logic [2:0] code);
    qual_target = 8'(8'h01 << code);
  endfunction

  function automatic logic [2:0] low_code(input logic [7:0] q23, input logic [7:0] q45, input int idx);
    case (idx)
      0:       low_code = q23[6:4];
      1:       low_code = q45[2:0];
      default: low_code = q45[6:4];
    endcase
  endfunction

  cmq_sync u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (comparator_raw),
    .sync_out (cmp_s)
  );

  // pulse-generator tick, one cycle wide
  assign tick = pulse_gen_prescale_select ? (st_r.prescale_cnt == `CMQ_TICK_DIV4_LAST)
                                          : ({1'b0, st_r.prescale_cnt[0]} == `CMQ_TICK_DIV2_LAST);

  always_comb begin
    logic [7:0] rd;
    logic       active;
    rd       = 8'h00;
    active   = 1'b0;
    st_nxt   = st_r;
    qual_set = 4'h0;
    edge_evt = 5'h00;

    st_nxt.prescale_cnt = 2'(st_r.prescale_cnt + 2'h1);
    st_nxt.cmp_prev     = cmp_s;

    // comparator two: count falling edges, restart after each qualified event
    if (st_r.cmp_prev[1] && !cmp_s[1]) begin
      if (8'(st_r.fall_cnt + 8'h01) == qual_target(st_r.qual_23[2:0])) begin
        qual_set[0]     = 1'b1;
        st_nxt.fall_cnt = 8'h00;
      end else begin
        st_nxt.fall_cnt = 8'(st_r.fall_cnt + 8'h01);
      end
    end

    // comparators three to five: uninterrupted low time in ticks
    for (int i = 0; i < 3; i++) begin
      active = (i != 0) || !st_r.qual_23[`CMQ_BIT_WINDOW_SEL] || pulse_gen_output_active;
      if (cmp_s[i + 2] || !active) begin
        st_nxt.low_cnt[i]  = 8'h00;
        st_nxt.low_done[i] = 1'b0;
      end else if (tick && !st_r.low_done[i]) begin
        if (8'(st_r.low_cnt[i] + 8'h01) == qual_target(low_code(st_r.qual_23, st_r.qual_45, i))) begin
          qual_set[i + 1]    = 1'b1;
          st_nxt.low_done[i] = 1'b1;
          st_nxt.low_cnt[i]  = 8'h00;
        end else begin
          st_nxt.low_cnt[i] = 8'(st_r.low_cnt[i] + 8'h01);
        end
      end
    end

    // comparator one debounce; outside synchronous mode it follows the input
    if (!pulse_gen_sync_mode || st_r.cmp_ctrl[0][`CMQ_DBT_MSB:0] == 5'h00) begin
      st_nxt.dbnc_out = cmp_s[0];
      st_nxt.dbnc_cnt = 5'h00;
    end else if (cmp_s[0] == st_r.dbnc_out) begin
      st_nxt.dbnc_cnt = 5'h00;
    end else if (tick) begin
      if (5'(st_r.dbnc_cnt + 5'h01) >= st_r.cmp_ctrl[0][`CMQ_DBT_MSB:0]) begin
        st_nxt.dbnc_out = cmp_s[0];
        st_nxt.dbnc_cnt = 5'h00;
      end else begin
        st_nxt.dbnc_cnt = 5'(st_r.dbnc_cnt + 5'h01);
      end
    end

    // edge-triggered comparator requests, bit i selects rising for comparator i+1
    for (int i = 0; i < 5; i++) begin
      edge_evt[i] = st_r.edge_sel[i] ? (!st_r.cmp_prev[i] && cmp_s[i])
                                     : (st_r.cmp_prev[i] && !cmp_s[i]);
    end

    // register writes; a flag written zero in the cycle it is set stays set
    st_nxt.irq_ctrl[3:0] = st_r.irq_ctrl[3:0] | qual_set;
    if (sfr_wr_en) begin
      case (sfr_addr)
        `CMQ_ADDR_IRQ_CTRL: begin
          st_nxt.irq_ctrl[7:4] = sfr_wdata[7:4];
          st_nxt.irq_ctrl[3:0] = (st_r.irq_ctrl[3:0] & sfr_wdata[3:0]) | qual_set;
        end
        `CMQ_ADDR_CMP1_CTRL: st_nxt.cmp_ctrl[0] = sfr_wdata & `CMQ_MASK_CMP1_CTRL;
        `CMQ_ADDR_CMP2_CTRL: st_nxt.cmp_ctrl[1] = sfr_wdata;
        `CMQ_ADDR_CMP3_CTRL: st_nxt.cmp_ctrl[2] = sfr_wdata;
        `CMQ_ADDR_CMP4_CTRL: st_nxt.cmp_ctrl[3] = sfr_wdata;
        `CMQ_ADDR_CMP5_CTRL: st_nxt.cmp_ctrl[4] = sfr_wdata;
        `CMQ_ADDR_QUAL_23:   st_nxt.qual_23     = sfr_wdata & `CMQ_MASK_QUAL_23;
        `CMQ_ADDR_QUAL_45:   st_nxt.qual_45     = sfr_wdata & `CMQ_MASK_QUAL_45;
        `CMQ_ADDR_EDGE_SEL:  st_nxt.edge_sel    = sfr_wdata & `CMQ_MASK_EDGE_SEL;
        default: ;
      endcase
    end

    // read data is captured on the strobe and held; unmapped offsets read zero
    case (sfr_addr)
      `CMQ_ADDR_IRQ_CTRL:  rd = st_r.irq_ctrl;
      `CMQ_ADDR_CMP1_CTRL: rd = st_r.cmp_ctrl[0];
      `CMQ_ADDR_CMP2_CTRL: rd = st_r.cmp_ctrl[1];
      `CMQ_ADDR_CMP3_CTRL: rd = st_r.cmp_ctrl[2];
      `CMQ_ADDR_CMP4_CTRL: rd = st_r.cmp_ctrl[3];
      `CMQ_ADDR_CMP5_CTRL: rd = st_r.cmp_ctrl[4];
      `CMQ_ADDR_QUAL_23:   rd = st_r.qual_23;
      `CMQ_ADDR_QUAL_45:   rd = st_r.qual_45;
      `CMQ_ADDR_EDGE_SEL:  rd = st_r.edge_sel;
      default:             rd = 8'h00;
    endcase
    if (sfr_rd_en) begin
      st_nxt.rdata = rd;
    end

    // one request line; edge events give a single-cycle pulse, flags hold it
    st_nxt.irq = comparator_group_irq_enable
               && ((|(st_r.irq_ctrl[3:0] & st_r.irq_ctrl[7:4])) || (|edge_evt));
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r         <= '0;
      st_r.qual_23 <= `CMQ_RST_QUAL_23;
      st_r.qual_45 <= `CMQ_RST_QUAL_45;
      // edge history starts at the idle level so no false edge follows reset
      st_r.cmp_prev <= 5'h1f;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      analog_ctrl.enable[i]            = st_r.cmp_ctrl[i][`CMQ_BIT_ENABLE];
      analog_ctrl.hysteresis_enable[i] = st_r.cmp_ctrl[i][`CMQ_BIT_HYST];
    end
    for (int i = 0; i < 4; i++) begin
      analog_ctrl.reference_code[i] = st_r.cmp_ctrl[i + 1][`CMQ_REF_MSB:0];
    end
  end

  assign sfr_rdata                = st_r.rdata;
  assign comparator_one_debounced = st_r.dbnc_out;
  assign qualified_flags          = st_r.irq_ctrl[3:0];
  assign comparator_irq           = st_r.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_FLAG_SET_WINS:
    assert property (qual_set[0] |=> qualified_flags[0])
    else $error("comparator two flag lost its set");

  AST_FLAG_CLEAR:
    assert property (sfr_wr_en && sfr_addr == `CMQ_ADDR_IRQ_CTRL && !sfr_wdata[1] && !qual_set[1]
                     |=> !qualified_flags[1])
    else $error("comparator three flag not cleared by zero write");

  AST_GROUP_GATE:
    assert property (!comparator_group_irq_enable |=> !comparator_irq)
    else $error("interrupt raised with group enable clear");

  AST_FLAG_REQUEST:
    assert property (comparator_group_irq_enable && (|(qualified_flags & st_r.irq_ctrl[7:4]))
                     |=> comparator_irq)
    else $error("enabled flag gave no request");

  AST_TICK_SPACING:
    assert property (tick |=> !tick)
    else $error("tick on consecutive cycles");

  AST_TICK_DIV4:
    assert property (tick && pulse_gen_prescale_select ##1 pulse_gen_prescale_select[*2] |-> !tick)
    else $error("divide-by-four tick too early");

  AST_LOW_RESTART:
    assert property (cmp_s[3] |=> st_r.low_cnt[1] == 8'h00)
    else $error("low counter kept count while high");

  AST_WINDOW:
    assert property (st_r.qual_23[`CMQ_BIT_WINDOW_SEL] && !pulse_gen_output_active |-> !qual_set[1])
    else $error("comparator three qualified outside window");

  AST_BYPASS:
    assert property (pulse_gen_sync_mode && st_r.cmp_ctrl[0][`CMQ_DBT_MSB:0] == 5'h00
                     |=> comparator_one_debounced == $past(cmp_s[0]))
    else $error("zero debounce count did not bypass");

  AST_ENABLE_WRITE:
    assert property (sfr_wr_en && sfr_addr == `CMQ_ADDR_CMP2_CTRL
                     |=> analog_ctrl.enable[1] == $past(sfr_wdata[7])
                         && analog_ctrl.reference_code[0] == $past(sfr_wdata[5:0]))
    else $error("comparator two control write not applied");

  AST_FALL_QUAL:
    assert property (st_r.qual_23[2:0] == 3'h0 && st_r.cmp_prev[1] && !cmp_s[1] |=> qualified_flags[0])
    else $error("single falling edge did not qualify");

  AST_FALL_RESTART:
    assert property (qual_set[0] |=> st_r.fall_cnt == 8'h00)
    else $error("comparator two count kept after qualifying");

  AST_LOW_FLAG:
    assert property (qual_set[1] |=> qualified_flags[1])
    else $error("comparator three flag not set");

  AST_LOW_ONCE:
    assert property (st_r.low_done[1] && !cmp_s[3] |-> !qual_set[2])
    else $error("comparator four qualified twice in one low interval");

  AST_WINDOW_HOLD:
    assert property (st_r.qual_23[`CMQ_BIT_WINDOW_SEL] && !pulse_gen_output_active |=> st_r.low_cnt[0] == 8'h00)
    else $error("comparator three counted outside window");

  AST_EDGE_RISE:
    assert property (comparator_group_irq_enable && st_r.edge_sel[4] && !st_r.cmp_prev[4] && cmp_s[4]
                     |=> comparator_irq)
    else $error("comparator five rising edge gave no request");

  AST_HYST_WRITE:
    assert property (sfr_wr_en && sfr_addr == `CMQ_ADDR_CMP4_CTRL
                     |=> analog_ctrl.hysteresis_enable[3] == $past(sfr_wdata[`CMQ_BIT_HYST]))
    else $error("comparator four hysteresis write not applied");

  AST_DBNC_TICK:
    assert property (pulse_gen_sync_mode && st_r.cmp_ctrl[0][`CMQ_DBT_MSB:0] != 5'h00 && !tick
                     |=> $stable(comparator_one_debounced))
    else $error("debounced output moved between ticks");

  AST_REF_WRITE:
    assert property (sfr_wr_en && sfr_addr == `CMQ_ADDR_CMP5_CTRL
                     |=> analog_ctrl.reference_code[3] == $past(sfr_wdata[`CMQ_REF_MSB:0]))
    else $error("comparator five reference write not applied");

  AST_TICK_DIV2:
    assert property (tick && !pulse_gen_prescale_select ##2 !pulse_gen_prescale_select |-> tick)
    else $error("divide-by-two tick missing");

  AST_EDGE_ONE_FALL:
    assert property (comparator_group_irq_enable && !st_r.edge_sel[0] && st_r.cmp_prev[0] && !cmp_s[0]
                     |=> comparator_irq)
    else $error("comparator one falling edge gave no request");

  AST_SYNC_DELAY:
    assert property ($past(rst_n) && $past(rst_n, 2) |-> cmp_s == $past(comparator_raw, 2))
    else $error("synchroniser delay is not two cycles");

  AST_IRQ_QUIET:
    assert property (!(|(qualified_flags & st_r.irq_ctrl[7:4])) && !(|edge_evt) |=> !comparator_irq)
    else $error("request raised with no enabled flag or edge");

endmodule

/* File: cmq_analog_model.sv */
// behavioural model of the five analogue comparators facing the qualifier
// assumes the bench commands each comparator's input state directly
`timescale 1ns/1ns
module cmq_analog_model (
  // control from the qualifier
  input  wire cmq_pkg::cmq_analog_ctrl_t analog_ctrl,
  // commanded state, bit0 = comparator one
  input  wire logic [4:0]                level,
  // comparator outputs
  output      logic [4:0]                comparator_raw
);
  // a disabled comparator rests high so it never looks like a low event
  assign comparator_raw = level | ~analog_ctrl.enable;
endmodule

/* File: tb_comparator_event_qualifier.sv */
// self-checking bench for the comparator event qualifier
// assumes cmq_top and cmq_analog_model are compiled alongside
`timescale 1ns/1ns
module tb_comparator_event_qualifier;
  logic                      clk_sys, rst_n, wr, rd, grp, psc, syncm, act, dbn, irq;
  logic [7:0]                addr, wdata, rdata;
  logic [4:0]                lvl, raw;
  logic [3:0]                flg;
  logic [5:0]                obs;
  cmq_pkg::cmq_analog_ctrl_t actl;
  int                        n_errors, checked;

  assign obs = {irq, dbn, flg};

  cmq_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(addr), .sfr_wr_en(wr), .sfr_rd_en(rd),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .comparator_group_irq_enable(grp), .pulse_gen_prescale_select(psc),
    .pulse_gen_sync_mode(syncm), .pulse_gen_output_active(act), .comparator_raw(raw), .analog_ctrl(actl),
    .comparator_one_debounced(dbn), .qualified_flags(flg), .comparator_irq(irq));
  cmq_analog_model u_cmp (.analog_ctrl(actl), .level(lvl), .comparator_raw(raw));

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // every input change lands 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    // one idle edge, so a following write never drops and raises the strobe in one step
    wr = 1'b0;
    tick(1);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    chk(n, rdata, e);
  endtask

  task automatic wait_bit(input int b, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && obs[b] !== v; i++) tick(1);
    if (i == lim) begin
      chk("wait bound", 8'h00, 8'h01);
      results();
    end
  endtask

  // a glitch in between would be missed by a single sample, so watch every cycle
  task automatic quiet(input string n, input int b, input logic v, input int lim);
    logic s;
    s = 1'b0;
    repeat (lim) begin
      tick(1);
      if (obs[b] !== v) s = 1'b1;
    end
    chk(n, {7'h0, s}, 8'h00);
  endtask

  task automatic t_regs();
    rd_chk("qual23 reset", 8'hc6, 8'h77);
    rd_chk("qual45 reset", 8'hc7, 8'h77);
    rd_chk("ctrl2 reset", 8'hc2, 8'h00);
    rd_chk("unmapped", 8'h00, 8'h00);
    wr_reg(8'hc2, 8'hff);
    chk("enable", {3'h0, actl.enable}, 8'h02);
    chk("hysteresis", {3'h0, actl.hysteresis_enable}, 8'h02);
    chk("ref code", {2'h0, actl.reference_code[0]}, 8'h3f);
    rd_chk("ctrl2", 8'hc2, 8'hff);
    wr_reg(8'hc1, 8'hff);
    rd_chk("ctrl1", 8'hc1, 8'hdf);
    wr_reg(8'hd7, 8'hff);
    rd_chk("edge sel", 8'hd7, 8'h1f);
    $display("test regs done");
  endtask

  task automatic pulse2();
    lvl[1] = 1'b0;
    tick(4);
    lvl[1] = 1'b1;
  endtask

  task automatic t_cmp2();
    for (int i = 1; i < 6; i++) wr_reg(8'hc0 + i[7:0], 8'h80);
    wr_reg(8'hd7, 8'h00);
    wr_reg(8'hc6, 8'h01);
    pulse2();
    quiet("cmp2 one fall", 0, 1'b0, 8);
    pulse2();
    wait_bit(0, 1'b1, 8);
    wr_reg(8'hbf, 8'h11);
    quiet("group off", 5, 1'b0, 3);
    grp = 1'b1;
    tick(2);
    chk("irq enabled", {7'h0, irq}, 8'h01);
    wr_reg(8'hbf, 8'h0e);
    tick(2);
    chk("flags cleared", {4'h0, flg}, 8'h00);
    chk("irq masked", {7'h0, irq}, 8'h00);
    grp = 1'b0;
    wr_reg(8'hc6, 8'h00);
    pulse2();
    chk("cmp2 single fall", {4'h0, flg}, 8'h01);
    wr_reg(8'hbf, 8'h00);
    $display("test cmp2 done");
  endtask

  task automatic t_low();
    wr_reg(8'hc7, 8'h02);
    lvl[3] = 1'b0;
    tick(4);
    lvl[3] = 1'b1;
    quiet("cmp4 short low", 2, 1'b0, 12);
    for (int p = 0; p < 2; p++) begin
      psc = p[0];
      lvl[3] = 1'b0;
      quiet("cmp4 early", 2, 1'b0, 6 * (p + 1));
      wait_bit(2, 1'b1, 24);
      lvl[3] = 1'b1;
      wr_reg(8'hbf, 8'h00);
    end
    $display("test low done");
  endtask

  task automatic t_win();
    wr_reg(8'hc6, 8'h87);
    lvl[2] = 1'b0;
    quiet("cmp3 outside window", 1, 1'b0, 12);
    act = 1'b1;
    wait_bit(1, 1'b1, 12);
    lvl[2] = 1'b1;
    act = 1'b0;
    wr_reg(8'hbf, 8'h00);
    $display("test window done");
  endtask

  task automatic t_dbnc();
    syncm = 1'b1;
    psc = 1'b1;
    wr_reg(8'hc1, 8'h83);
    chk("debounce idle", {7'h0, dbn}, 8'h01);
    lvl[0] = 1'b0;
    tick(6);
    lvl[0] = 1'b1;
    quiet("short glitch", 4, 1'b1, 16);
    lvl[0] = 1'b0;
    quiet("debounce early", 4, 1'b1, 8);
    wait_bit(4, 1'b0, 24);
    wr_reg(8'hc1, 8'h80);
    lvl[0] = 1'b1;
    tick(3);
    chk("bypass", {7'h0, dbn}, 8'h01);
    syncm = 1'b0;
    $display("test debounce done");
  endtask

  task automatic t_edge();
    grp = 1'b1;
    wr_reg(8'hd7, 8'h01);
    lvl[4] = 1'b0;
    wait_bit(5, 1'b1, 8);
    lvl[4] = 1'b1;
    quiet("cmp5 rise", 5, 1'b0, 8);
    lvl[0] = 1'b0;
    quiet("cmp1 fall", 5, 1'b0, 8);
    lvl[0] = 1'b1;
    wait_bit(5, 1'b1, 8);
    grp = 1'b0;
    $display("test edge done");
  endtask

  task automatic results();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    {rst_n, wr, rd, grp, psc, syncm, act} = 7'h00;
    addr = 8'h00;
    wdata = 8'h00;
    lvl = 5'h1f;
    n_errors = 0;
    checked = 0;
    tick(12);
    rst_n = 1'b1;
    tick(1);
    t_regs();
    t_cmp2();
    t_low();
    t_win();
    t_dbnc();
    t_edge();
    results();
  end
endmodule
